// ==== design/sbcsf_defs.svh ====
// Purpose: constants for the serial bus control and status flag block
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes:   the control register byte sits in the low bits of its word
//
// Overview of operation
// - Master bit sets on generated START, clears on generated STOP or lost arbitration.
// - Transmit bit sets on START generated or early data write; clears otherwise.
// - Start flag sets after START plus address received; only software clears it.
// - Writing one to start flag makes the block master and requests START.
// - Writing one to stop flag as master schedules STOP after next acknowledge.
// - Stop flag reads pending STOP as master, detected STOP as slave.
// - Stop flag sets on STOP detected as addressed slave or lost to STOP.
// - Without hardware acknowledge, request flag sets per received byte, clears after acknowledge.
// - Arbitration lost on unexpected repeated START as master with start flag low.
// - Arbitration lost when clock line low while producing STOP or repeated START.
// - Arbitration lost when data line low while driving one, except acknowledge.
// - Arbitration-lost flag clears when software clears the interrupt flag, unless a loss occurs in that same cycle.
// - Acknowledge bit follows received acknowledge: low sets, high clears.
// - Software acknowledge write selects outgoing value: zero NACK, one ACK.
// - Interrupt flag sets on START, arbitration loss, byte done, address, STOP.
// - While interrupt flag set, clock line held low; only software clears it.
// - Writing zero clears interrupt and steps state machine; one forces interrupt.
// - Control register at offset 0xC0, bit writable singly, resets to zero; the APB port here writes its bits only together as a whole word.
// - Start and stop both set as master give STOP then START.
// - Clearing interrupt without acknowledge write sends NACK in software mode.
`ifndef SBCSF_DEFS_SVH
`define SBCSF_DEFS_SVH

`define SBCSF_ADDR_CTRL     8'hC0
`define SBCSF_ADDR_EVENT    8'hC4
`define SBCSF_ADDR_CFG      8'hC8
`define SBCSF_ADDR_TXDATA   8'hCC
`define SBCSF_CTRL_RESET    8'h00
`define SBCSF_BIT_MASTER    7
`define SBCSF_BIT_TRANSMIT_DIRECTION_FLAG    6
`define SBCSF_BIT_START     5
`define SBCSF_BIT_STOP      4
`define SBCSF_BIT_ACK_REQUEST_FLAG     3
`define SBCSF_BIT_ARBITRATION_LOST_FLAG   2
`define SBCSF_BIT_ACK       1
`define SBCSF_BIT_INT       0
`define SBCSF_EV_START_GEN  0
`define SBCSF_EV_STOP_GEN   1
`define SBCSF_EV_START_DET  2
`define SBCSF_EV_STOP_DET   3
`define SBCSF_EV_ADDR_RX    4
`define SBCSF_EV_BYTE_RX    5
`define SBCSF_EV_BYTE_TX    6
`define SBCSF_EV_ACK_DONE   7
`define SBCSF_EV_WIDTH      8
`define SBCSF_CFG_HWACK     0
`define SBCSF_CFG_SLAVE     1
`define SBCSF_ZERO32        32'h0000_0000

`endif

// ==== design/sbcsf_pkg.sv ====
// Purpose: shared types for the serial bus control and status flag block
// Assumes: constants live in sbcsf_defs.svh
// Notes:   states of the condition sequencer
package sbcsf_pkg;
    typedef enum logic [2:0] {
        SBCSF_IDLE,
        SBCSF_GEN_STOP,
        SBCSF_GEN_START,
        SBCSF_XFER
    } sbcsf_seq_t;
endpackage : sbcsf_pkg

// ==== design/sbcsf_control.sv ====
// Purpose: control register, flag logic and bus condition sequencer
// Assumes: bit-level shifter and address match sit outside; they report events
// Notes:   event inputs are one-cycle pulses on clk_sys
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "sbcsf_defs.svh"

module sbcsf_control
    import sbcsf_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // bus line samples
    input  wire logic        sclIn,
    input  wire logic        sdaIn,
    input  wire logic        sdaDriveOne,
    input  wire logic        ackBitPhase,
    // clock line hold: open drain, enable pulls low
    output logic             sclOut,
    output logic             sclOe,
    // outgoing acknowledge value for the shifter
    output logic             ackOutValue,
    // condition requests to the line driver
    output logic             genStartReq,
    output logic             genStopReq,
    output logic             interruptLevel
);

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic        access;
    logic        wrCtrl;
    logic        wrEvent;
    logic        wrCfg;
    logic        wrData;
    logic        mapped;

    // an access completes in its first access cycle
    assign access  = psel && penable;
    assign wrCtrl  = access && pwrite && (paddr == `SBCSF_ADDR_CTRL);
    assign wrEvent = access && pwrite && (paddr == `SBCSF_ADDR_EVENT);
    assign wrCfg   = access && pwrite && (paddr == `SBCSF_ADDR_CFG);
    assign wrData  = access && pwrite && (paddr == `SBCSF_ADDR_TXDATA);
    assign mapped  = (paddr == `SBCSF_ADDR_CTRL) || (paddr == `SBCSF_ADDR_EVENT)
                  || (paddr == `SBCSF_ADDR_CFG)  || (paddr == `SBCSF_ADDR_TXDATA);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic        master_r;
    logic        transmit_direction_flag_r;
    logic        start_r;
    logic        stop_r;
    logic        ackReq_r;
    logic        arbitration_lost_flag_r;
    logic        ack_r;
    logic        int_r;
    logic        ackWritten_r;
    logic        hwAck_r;
    logic        slaveAddressed_r;
    logic        dataWritten_r;
    logic        stepPulse_r;
    logic [`SBCSF_EV_WIDTH-1:0] events_r;
    sbcsf_seq_t  seq_r;

    // events as written by the bit engine through the event port
    logic evStartGen;
    logic evStopGen;
    logic evStartDet;
    logic evStopDet;
    logic evAddrRx;
    logic evByteRx;
    logic evByteTx;
    logic evAckDone;

    // event pulses come from writes to the event port
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            events_r <= '0;
        end else if (wrEvent) begin
            events_r <= pwdata[`SBCSF_EV_WIDTH-1:0];
        end else begin
            events_r <= '0;
        end
    end

    assign evStartGen = events_r[`SBCSF_EV_START_GEN];
    assign evStopGen  = events_r[`SBCSF_EV_STOP_GEN];
    assign evStartDet = events_r[`SBCSF_EV_START_DET];
    assign evStopDet  = events_r[`SBCSF_EV_STOP_DET];
    assign evAddrRx   = events_r[`SBCSF_EV_ADDR_RX];
    assign evByteRx   = events_r[`SBCSF_EV_BYTE_RX];
    assign evByteTx   = events_r[`SBCSF_EV_BYTE_TX];
    assign evAckDone  = events_r[`SBCSF_EV_ACK_DONE];

    // ------------------------------------------------------------
    // arbitration loss sources
    // ------------------------------------------------------------
    logic lostRepStart;
    logic lostSclLow;
    logic lostSdaLow;
    logic lostStop;
    logic arbLoss;
    logic intClear;

    assign lostRepStart = master_r && !start_r && evStartDet && (seq_r == SBCSF_XFER);
    assign lostSclLow   = ((seq_r == SBCSF_GEN_STOP) || (seq_r == SBCSF_GEN_START)) && !sclIn;
    assign lostSdaLow   = sdaDriveOne && !sdaIn && !ackBitPhase && (seq_r != SBCSF_IDLE);
    assign lostStop     = master_r && evStopDet && !evStopGen;
    assign arbLoss      = lostRepStart || lostSclLow || lostSdaLow || lostStop;
    assign intClear     = wrCtrl && !pwdata[`SBCSF_BIT_INT];

    // configuration: hardware acknowledge enable and slave addressed status
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hwAck_r          <= 1'b0;
            slaveAddressed_r <= 1'b0;
        end else if (wrCfg) begin
            hwAck_r          <= pwdata[`SBCSF_CFG_HWACK];
            slaveAddressed_r <= pwdata[`SBCSF_CFG_SLAVE];
        end
    end

    // data register written since the last START, generated or detected
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dataWritten_r <= 1'b0;
        end else if (wrData) begin
            dataWritten_r <= 1'b1;
        end else if (evStartGen || evStartDet) begin
            dataWritten_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // control register bits
    // ------------------------------------------------------------
    // master indicator
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            master_r <= 1'b0;
        end else if (evStartGen) begin
            master_r <= 1'b1;
        end else if (evStopGen || arbLoss) begin
            master_r <= 1'b0;
        end
    end

    // transmit direction indicator
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            transmit_direction_flag_r <= 1'b0;
        end else if (evStartGen) begin
            transmit_direction_flag_r <= 1'b1;
        end else if (evStartDet || arbLoss) begin
            transmit_direction_flag_r <= 1'b0;
        end else if (evAddrRx || evAckDone) begin
            transmit_direction_flag_r <= dataWritten_r;
        end
    end

    // start flag: hardware sets, software alone clears
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            start_r <= 1'b0;
        end else if (evAddrRx) begin
            start_r <= 1'b1;
        end else if (wrCtrl) begin
            start_r <= pwdata[`SBCSF_BIT_START];
        end
    end

    // stop flag: pending stop as master, detected stop as slave
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stop_r <= 1'b0;
        end else if ((evStopDet && slaveAddressed_r) || (lostStop)) begin
            stop_r <= 1'b1;
        end else if (evStopGen) begin
            stop_r <= 1'b0;
        end else if (wrCtrl) begin
            stop_r <= pwdata[`SBCSF_BIT_STOP] && (master_r || start_r);
        end
    end

    // acknowledge request: only in software acknowledge mode
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ackReq_r <= 1'b0;
        end else if (evByteRx && !hwAck_r) begin
            ackReq_r <= 1'b1;
        end else if (evAckDone) begin
            ackReq_r <= 1'b0;
        end
    end

    // arbitration lost: set wins over the clear that follows software
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            arbitration_lost_flag_r <= 1'b0;
        end else if (arbLoss) begin
            arbitration_lost_flag_r <= 1'b1;
        end else if (intClear) begin
            arbitration_lost_flag_r <= 1'b0;
        end
    end

    // acknowledge bit: received value or software choice
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else if (evByteTx) begin
            ack_r <= !sdaIn;
        end else if (wrCtrl) begin
            ack_r <= pwdata[`SBCSF_BIT_ACK];
        end
    end

    // track whether software chose the acknowledge since the last received byte
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ackWritten_r <= 1'b0;
        end else if (evByteRx) begin
            ackWritten_r <= 1'b0;
        end else if (wrCtrl && pwdata[`SBCSF_BIT_INT]) begin
            ackWritten_r <= 1'b1;
        end
    end

    // interrupt flag: START generated, arbitration loss, byte, address or addressed-slave STOP sets it, set wins over software clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            int_r <= 1'b0;
        end else if (evStartGen || arbLoss || evByteTx || evByteRx || evAddrRx
                     || (evStopDet && slaveAddressed_r)) begin
            int_r <= 1'b1;
        end else if (wrCtrl) begin
            int_r <= pwdata[`SBCSF_BIT_INT];
        end
    end

    // one-cycle step pulse when software releases the interrupt
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stepPulse_r <= 1'b0;
        end else begin
            stepPulse_r <= intClear && int_r;
        end
    end

    // ------------------------------------------------------------
    // condition sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            seq_r <= SBCSF_IDLE;
        end else if (arbLoss) begin
            seq_r <= SBCSF_IDLE;
        end else begin
            unique case (seq_r)
                SBCSF_IDLE: begin
                    if (start_r && !int_r) begin
                        seq_r <= SBCSF_GEN_START;
                    end
                end
                SBCSF_GEN_START: begin
                    if (evStartGen) begin
                        seq_r <= SBCSF_XFER;
                    end
                end
                SBCSF_XFER: begin
                    if (stepPulse_r && stop_r && master_r) begin
                        seq_r <= SBCSF_GEN_STOP;
                    end else if (stepPulse_r && start_r && master_r) begin
                        seq_r <= SBCSF_GEN_START;
                    end
                end
                SBCSF_GEN_STOP: begin
                    if (evStopGen) begin
                        seq_r <= start_r ? SBCSF_GEN_START : SBCSF_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sclOut         <= 1'b0;
            sclOe          <= 1'b0;
            genStartReq    <= 1'b0;
            genStopReq     <= 1'b0;
            ackOutValue    <= 1'b0;
            interruptLevel <= 1'b0;
        end else begin
            sclOut         <= 1'b0;
            sclOe          <= int_r;
            genStartReq    <= (seq_r == SBCSF_GEN_START) && !int_r;
            genStopReq     <= (seq_r == SBCSF_GEN_STOP);
            ackOutValue    <= ack_r && (hwAck_r || ackWritten_r || !ackReq_r);
            interruptLevel <= int_r;
        end
    end

    // apb answer, one wait-free access phase
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata  <= `SBCSF_ZERO32;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= `SBCSF_ZERO32;
            if (psel && !penable && !pwrite && (paddr == `SBCSF_ADDR_CTRL)) begin
                prdata <= {24'h00_0000, master_r, transmit_direction_flag_r, start_r, stop_r,
                           ackReq_r, arbitration_lost_flag_r, ack_r, int_r};
            end else if (psel && !penable && !pwrite && (paddr == `SBCSF_ADDR_CFG)) begin
                prdata <= {30'h0000_0000, slaveAddressed_r, hwAck_r};
            end
        end
    end

endmodule : sbcsf_control

// ==== tb/sbcsf_control_props.sv ====
// Purpose: port checks for the control block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound below to every control block
`timescale 1ns/1ps
`include "sbcsf_defs.svh"

module sbcsf_control_props
    import sbcsf_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sclIn,
    input wire logic        sdaIn,
    input wire logic        sdaDriveOne,
    input wire logic        ackBitPhase,
    input wire logic        sclOut,
    input wire logic        sclOe,
    input wire logic        ackOutValue,
    input wire logic        genStartReq,
    input wire logic        genStopReq,
    input wire logic        interruptLevel
);
    // --------------------
    // helpers
    // --------------------
    logic ctlWr;
    logic clrWr;
    // control write taken at this edge, and one that clears the flag
    assign ctlWr = psel && penable && pwrite && pready && (paddr == `SBCSF_ADDR_CTRL);
    assign clrWr = ctlWr && !pwdata[`SBCSF_BIT_INT];
    // --------------------
    // assertions
    // --------------------
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_ready_in_access: assert property (psel && !penable |=> pready)
        else $error("ready late");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held");
    a_scl_hold_int: assert property (sclOe == interruptLevel)
        else $error("clock hold differs from flag");
    a_reset_clears_outs: assert property ($fell(rst) |-> !interruptLevel && !genStartReq && !genStopReq)
        else $error("outputs not clear after reset");
    a_force_int: assert property (ctlWr && pwdata[`SBCSF_BIT_INT] |-> ##[1:2] interruptLevel)
        else $error("forced interrupt missing");
    a_int_sw_clear: assert property ($fell(interruptLevel) |-> $past(clrWr) || $past(clrWr, 2))
        else $error("interrupt cleared without write");
    a_start_request: assert property (ctlWr && pwdata[`SBCSF_BIT_START] && !pwdata[`SBCSF_BIT_STOP] |-> ##[1:3] genStartReq)
        else $error("no start request");
    // an acknowledge written while the flag stays set counts as chosen first
    a_ack_value: assert property (ctlWr && pwdata[`SBCSF_BIT_ACK] && pwdata[`SBCSF_BIT_INT] |-> ##[1:2] ackOutValue)
        else $error("ack value not taken");
endmodule : sbcsf_control_props

bind sbcsf_control sbcsf_control_props sbcsf_control_props_i (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaDriveOne(sdaDriveOne), .ackBitPhase(ackBitPhase), .sclOut(sclOut), .sclOe(sclOe),
    .ackOutValue(ackOutValue), .genStartReq(genStartReq), .genStopReq(genStopReq),
    .interruptLevel(interruptLevel)
);

// ==== tb/sbcsf_bus_partner.sv ====
// Purpose: far-side devices on the two-wire bus
// Assumes: both lines have pull-ups; every party only pulls low
// Notes:   the bench commands when a far device pulls a line
`timescale 1ns/1ps

module sbcsf_bus_partner
    import sbcsf_pkg::*;
(
    input  wire logic sclOut,
    input  wire logic sclOe,
    input  wire logic sdaDriveOne,
    input  wire logic holdSclLow,
    input  wire logic pullSdaLow,
    output logic      sclIn,
    output logic      sdaIn
);
    // ------------------------------
    // wired-and of open-drain lines
    // ------------------------------
    // clock low when the block holds it or a far device stretches it
    assign sclIn = !(sclOe && !sclOut) && !holdSclLow;
    // data is the shifter level anded with the far pull
    assign sdaIn = sdaDriveOne && !pullSdaLow;
endmodule : sbcsf_bus_partner

// ==== tb/sbcsf_control_tb.sv ====
// Purpose: self-checking bench for the control block
// Assumes: far side modelled by sbcsf_bus_partner
// Notes:   protocol events are injected through the event word
`timescale 1ns/1ps
`include "sbcsf_defs.svh"

module sbcsf_control_tb
    import sbcsf_pkg::*;
;
    localparam logic [7:0] CTL = `SBCSF_ADDR_CTRL;
    localparam logic [7:0] CFG = `SBCSF_ADDR_CFG;
    logic        clk_sys = 1'h0;
    logic        rst = 1'h1;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        sdaDriveOne = 1'h0;
    logic        ackBitPhase = 1'h0;
    logic        holdSclLow = 1'h0;
    logic        pullSdaLow = 1'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, sclIn, sdaIn, sclOut, sclOe;
    logic        ackOutValue, genStartReq, genStopReq, interruptLevel;
    logic [40:0] expQ[$];
    int          miscompares = 0;
    int          nChecks = 0;

    always #5 clk_sys = ~clk_sys;

    sbcsf_control sbcsf_control_i (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(sclIn), .sdaIn(sdaIn),
        .sdaDriveOne(sdaDriveOne), .ackBitPhase(ackBitPhase), .sclOut(sclOut), .sclOe(sclOe),
        .ackOutValue(ackOutValue), .genStartReq(genStartReq), .genStopReq(genStopReq),
        .interruptLevel(interruptLevel)
    );
    sbcsf_bus_partner sbcsf_bus_partner_i (
        .sclOut(sclOut), .sclOe(sclOe), .sdaDriveOne(sdaDriveOne), .holdSclLow(holdSclLow),
        .pullSdaLow(pullSdaLow), .sclIn(sclIn), .sdaIn(sdaIn)
    );
    // ---------------------
    // tasks
    // ---------------------
    task automatic chk(input string w, input logic [32:0] seen, input logic [32:0] e);
        nChecks++;
        if (seen !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", w, e, seen);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d mismatches %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    // one apb transfer: setup, then access until ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        // look at ready while it stands, then take the access at the next rising edge
        do begin
            @(negedge clk_sys);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            miscompares++;
            end_sim();
        end
        @(posedge clk_sys);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'h1, a, {24'h00_0000, d});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input logic err);
        expQ.push_back({m, err, 24'h00_0000, e});
        apb(1'h0, a, 32'h0000_0000);
    endtask : rd

    // event pulse, then room for the flags to update
    task automatic ev(input logic [7:0] m);
        wr(`SBCSF_ADDR_EVENT, m);
        repeat (3) @(posedge clk_sys);
    endtask : ev

    task automatic look(input string w, ref logic s, input logic e);
        repeat (3) @(negedge clk_sys);
        chk(w, 33'(s), 33'(e));
    endtask : look

    // compares each read with the oldest note
    always @(posedge clk_sys) begin
        logic [40:0] e;
        if (psel && penable && pready && !pwrite && expQ.size() > 0) begin
            e = expQ.pop_front();
            chk("read", {pslverr, prdata & {24'hFF_FFFF, e[40:33]}}, e[32:0]);
        end
    end
    // ---------------------
    // scenarios
    // ---------------------
    initial begin
        void'($urandom(87168));
        repeat (10) @(posedge clk_sys);
        rst <= 1'h0;
        rd(CTL, 8'hFF, 8'h00, 1'h0);
        rd(8'(32'hD0 + 32'h4 * ($urandom % 32'hC)), 8'hFF, 8'h00, 1'h1);
        wr(CFG, 8'h00);
        // master start after an early data write
        wr(`SBCSF_ADDR_TXDATA, 8'($urandom));
        wr(CTL, 8'h20);
        ev(8'h01);
        rd(CTL, 8'hFD, 8'hE1, 1'h0);
        look("sclIn", sclIn, 1'h0);
        wr(CTL, 8'h10);
        rd(CTL, 8'h11, 8'h10, 1'h0);
        ev(8'h80);
        ev(8'h02);
        rd(CTL, 8'h90, 8'h00, 1'h0);
        // stop and start requested together
        wr(CTL, 8'h20);
        ev(8'h01);
        wr(CTL, 8'h30);
        ev(8'h80);
        look("stopReq", genStopReq, 1'h1);
        ev(8'h02);
        look("startReq", genStartReq, 1'h1);
        ev(8'h01);
        wr(CTL, 8'h00);
        // data pulled low while driving one, ack bit first
        for (int k = 1; k >= 0; k--) begin
            ackBitPhase <= k[0];
            sdaDriveOne <= 1'h1;
            pullSdaLow <= 1'h1;
            repeat (3) @(posedge clk_sys);
            pullSdaLow <= 1'h0;
            rd(CTL, 8'h85, k[0] ? 8'h80 : 8'h05, 1'h0);
        end
        wr(CTL, 8'h00);
        rd(CTL, 8'h05, 8'h00, 1'h0);
        // unwanted repeated start as master
        wr(CTL, 8'h20);
        ev(8'h01);
        wr(CTL, 8'h00);
        ev(8'h04);
        rd(CTL, 8'h45, 8'h05, 1'h0);
        wr(CTL, 8'h00);
        // received acknowledge, low then high
        ackBitPhase <= 1'h1;
        for (int k = 1; k >= 0; k--) begin
            pullSdaLow <= k[0];
            ev(8'h40);
            rd(CTL, 8'h03, {6'h00, k[0], 1'h1}, 1'h0);
            wr(CTL, 8'h00);
        end
        // addressed slave with software acknowledge
        wr(CFG, 8'h02);
        ev(8'h04);
        ev(8'h10);
        rd(CTL, 8'h21, 8'h21, 1'h0);
        wr(CTL, 8'h00);
        for (int k = 1; k >= 0; k--) begin
            ev(8'h20);
            rd(CTL, 8'h09, 8'h09, 1'h0);
            // ack chosen first only when k is set; otherwise clear alone must give nack
            if (k[0]) begin
                wr(CTL, 8'h03);
            end
            wr(CTL, 8'h02);
            look("ackOut", ackOutValue, k[0]);
            ev(8'h80);
            rd(CTL, 8'h08, 8'h00, 1'h0);
        end
        ev(8'h08);
        rd(CTL, 8'h11, 8'h11, 1'h0);
        wr(CTL, 8'h00);
        wr(CFG, 8'h03);
        ev(8'h20);
        rd(CTL, 8'h08, 8'h00, 1'h0);
        // forced interrupt, then cleared
        wr(CTL, 8'h01);
        look("sclIn", sclIn, 1'h0);
        wr(CTL, 8'h00);
        rd(CTL, 8'h01, 8'h00, 1'h0);
        repeat (3) @(posedge clk_sys);
        if (expQ.size() != 0) begin
            miscompares++;
        end
        end_sim();
    end
endmodule : sbcsf_control_tb
